// file: rtl/ibf_i2c_front.sv
// What this block does
// - bytes only, shifted onto the bus most significant bit first.
// - each unit is eight data bits plus one acknowledge bit.
// - after eighth scl fall the data driver releases sda and reads acknowledge.
// - sda changes only with scl low; sampled on scl rising edge.
// - sda moving while scl is high is a condition, not data.
// - with port enabled in i2c mode, pins are open-drain driving zero.
// - hold select gives at least 300 ns sda hold after scl falls.
// - start is sda falling with scl high; bus goes idle to active.
// - master sees sda already low before driving start: bus collision.
// - stop is sda rising with scl high.
// - stop valid only after one scl low period since start.
// - restart accepted wherever a stop would be valid.
// - restart resets slave logic, ready for an address byte.
// - 10-bit read: restart after full match, high byte with read set.
// - full 10-bit write match sets prior match flag until cleared.
// - sda sampled low while driving high is a bus collision.
// - lost arbitration in general call read: stop driving, let winner finish.
// - bus idle only when no master and both lines high.
// - matched read supplies each following byte until the master nacks, restarts or stops.
// - in 7-bit mode, address matches when equal to slave address register, or zero with general call enabled.
// - read/write bit is one for read, zero for write.
// - 10-bit first byte compared against 11110, a9, a8, zero.
`timescale 1ns/1ps
module ibf_i2c_front
    import ibf_pkg::*;
#(
    parameter int HOLD_LONG = HOLD_LONG_CYC
)(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_port_enable_bit,
    input wire logic i_i2c_mode,
    input wire logic i_ten_bit_mode,
    input wire logic i_sda_hold_select,
    input wire logic [7:0] i_slave_address_reg,
    input wire logic [7:0] i_slave_address_lo,
    input wire logic i_general_call_en,
    input wire logic [7:0] i_tx_data,
    input wire logic i_start_req,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_scl_out,
    output logic o_scl_oe,
    output logic [7:0] o_rx_data,
    output logic o_rx_valid,
    output logic o_tx_load,
    output logic o_ack_in,
    output logic o_addr_match,
    output logic o_read_req,
    output logic o_prior_match,
    output logic o_bus_collision,
    output logic o_arb_lost,
    output logic o_start_seen,
    output logic o_stop_seen,
    output logic o_bus_idle
);
    import ibf_pkg::*;

    ibf_pins_if pins ();

    ibf_cond_det u_cond (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_pins(pins.cond)
    );

    ibf_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_shift_reg;
    logic sda_drive_low_reg;
    logic sda_pend_reg;
    logic pend_valid_reg;
    logic [HOLD_CNT_W-1:0] hold_cnt_reg;
    logic ack_phase_reg;
    logic gc_read_reg;
    logic addr_ack_reg;
    logic tx_live_reg;
    logic enabled;
    logic [7:0] rx_byte;
    logic byte_done;
    logic hi_match;

    function automatic logic [7:0] ten_hdr(input logic [7:0] addr, input logic rw);
        ten_hdr = {TEN_BIT_HDR, addr[2:1], rw};
    endfunction

    assign enabled = i_port_enable_bit && i_i2c_mode;
    assign rx_byte = {shift_reg[6:0], pins.sda_s};
    assign byte_done = pins.rise_p && (bit_cnt_reg == 4'(ACK_BIT_IDX - 1));
    assign hi_match = {rx_byte[7:1], 1'b0} == ten_hdr(i_slave_address_reg, 1'b0);

    // ----------------------------------------
    // bit counter and receive shifter
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bit_cnt_reg <= BITCNT_RST;
            shift_reg <= BYTE_RST;
        end else if (!enabled || pins.start_p || pins.stop_p) begin
            bit_cnt_reg <= BITCNT_RST;
        end else if (pins.rise_p) begin
            shift_reg <= rx_byte;
            if (bit_cnt_reg == 4'(BITS_PER_UNIT - 1)) begin
                bit_cnt_reg <= BITCNT_RST;
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ack_phase_reg <= 1'b0;
        end else if (!enabled || pins.start_p || pins.stop_p) begin
            ack_phase_reg <= 1'b0;
        end else if (pins.fall_p) begin
            ack_phase_reg <= bit_cnt_reg == 4'(ACK_BIT_IDX);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            addr_ack_reg <= 1'b0;
        end else if (!enabled || pins.start_p || pins.stop_p) begin
            addr_ack_reg <= 1'b0;
        end else if (byte_done) begin
            // an address byte is acked even when the slave goes on to transmit
            addr_ack_reg <= state_reg == IBF_ADDR || state_reg == IBF_ADDR_LO;
        end
    end

    // ----------------------------------------
    // slave address state machine
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= IBF_IDLE;
            o_addr_match <= 1'b0;
            o_read_req <= 1'b0;
            o_prior_match <= 1'b0;
            gc_read_reg <= 1'b0;
        end else if (!enabled || pins.stop_p) begin
            state_reg <= IBF_IDLE;
            o_read_req <= 1'b0;
            o_addr_match <= 1'b0;
            o_prior_match <= 1'b0;
            gc_read_reg <= 1'b0;
        end else if (pins.start_p) begin
            state_reg <= IBF_ADDR;
            o_read_req <= 1'b0;
            o_addr_match <= 1'b0;
            gc_read_reg <= 1'b0;
        end else if (o_arb_lost) begin
            state_reg <= IBF_IGNORE;
        end else if (byte_done) begin
            unique case (state_reg)
                IBF_ADDR: begin
                    if (i_ten_bit_mode) begin
                        if (!hi_match) begin
                            o_prior_match <= 1'b0;
                            state_reg <= IBF_IGNORE;
                        end else if (!rx_byte[0]) begin
                            o_prior_match <= 1'b0;
                            state_reg <= IBF_ADDR_LO;
                        end else if (o_prior_match) begin
                            o_addr_match <= 1'b1;
                            o_read_req <= 1'b1;
                            state_reg <= IBF_TX;
                        end else begin
                            state_reg <= IBF_IGNORE;
                        end
                    end else if (rx_byte[7:1] == i_slave_address_reg[7:1]) begin
                        o_addr_match <= 1'b1;
                        o_read_req <= rx_byte[0];
                        state_reg <= rx_byte[0] ? IBF_TX : IBF_RX;
                    end else if (i_general_call_en && rx_byte[7:1] == 7'h00) begin
                        o_addr_match <= 1'b1;
                        o_read_req <= rx_byte[0];
                        gc_read_reg <= rx_byte[0];
                        state_reg <= rx_byte[0] ? IBF_TX : IBF_RX;
                    end else begin
                        state_reg <= IBF_IGNORE;
                    end
                end
                IBF_ADDR_LO: begin
                    if (rx_byte == i_slave_address_lo) begin
                        o_addr_match <= 1'b1;
                        o_prior_match <= 1'b1;
                        state_reg <= IBF_RX;
                    end else begin
                        state_reg <= IBF_IGNORE;
                    end
                end
                IBF_IDLE, IBF_RX, IBF_TX, IBF_IGNORE: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // ----------------------------------------
    // byte outputs
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rx_data <= BYTE_RST;
            o_rx_valid <= 1'b0;
        end else begin
            o_rx_valid <= byte_done && state_reg == IBF_RX;
            if (byte_done && state_reg != IBF_IGNORE) begin
                o_rx_data <= rx_byte;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ack_in <= 1'b0;
        end else if (pins.rise_p && bit_cnt_reg == 4'(ACK_BIT_IDX) && state_reg == IBF_TX) begin
            o_ack_in <= !pins.sda_s;
        end
    end

    // ----------------------------------------
    // transmit shifter and sda drive request
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_shift_reg <= BYTE_RST;
            sda_pend_reg <= 1'b0;
            pend_valid_reg <= 1'b0;
            tx_live_reg <= 1'b0;
            o_tx_load <= 1'b0;
        end else begin
            o_tx_load <= 1'b0;
            pend_valid_reg <= 1'b0;
            if (!enabled || pins.start_p || pins.stop_p) begin
                sda_pend_reg <= 1'b0;
                tx_live_reg <= 1'b0;
                pend_valid_reg <= 1'b1;
            end else if (pins.fall_p) begin
                pend_valid_reg <= 1'b1;
                if (bit_cnt_reg == 4'(ACK_BIT_IDX)) begin
                    // ack slot: the receiving side pulls low, the sender lets go
                    sda_pend_reg <= state_reg == IBF_RX || state_reg == IBF_ADDR_LO
                        || (state_reg == IBF_TX && addr_ack_reg);
                end else if (state_reg == IBF_TX && ack_phase_reg) begin
                    // a nack ends the read and leaves sda free for the stop
                    if (addr_ack_reg || o_ack_in) begin
                        sda_pend_reg <= !i_tx_data[7];
                        tx_shift_reg <= {i_tx_data[6:0], 1'b0};
                        tx_live_reg <= 1'b1;
                        o_tx_load <= 1'b1;
                    end else begin
                        sda_pend_reg <= 1'b0;
                        tx_live_reg <= 1'b0;
                    end
                end else if (state_reg == IBF_TX) begin
                    sda_pend_reg <= !tx_shift_reg[7];
                    tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                end else begin
                    sda_pend_reg <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // hold timer: sda changes only after the hold delay past scl fall
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hold_cnt_reg <= '0;
            sda_drive_low_reg <= 1'b0;
        end else if (pend_valid_reg) begin
            // long hold helps heavily loaded buses at a cost in data setup margin
            hold_cnt_reg <= i_sda_hold_select ? HOLD_CNT_W'(HOLD_LONG) : HOLD_CNT_W'(HOLD_SHORT_CYC);
        end else if (hold_cnt_reg != '0) begin
            hold_cnt_reg <= hold_cnt_reg - 1'b1;
            if (hold_cnt_reg == HOLD_CNT_W'(1)) begin
                sda_drive_low_reg <= sda_pend_reg && enabled && !o_arb_lost;
            end
        end else if (!enabled || o_arb_lost) begin
            sda_drive_low_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // collision and arbitration
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bus_collision <= 1'b0;
            o_arb_lost <= 1'b0;
        end else begin
            if (i_start_req && enabled && !pins.sda_s) begin
                o_bus_collision <= 1'b1;
            end else if (pins.rise_p && state_reg == IBF_TX && tx_live_reg && !ack_phase_reg && !sda_drive_low_reg
                && !pins.sda_s && bit_cnt_reg != 4'(ACK_BIT_IDX)) begin
                o_bus_collision <= 1'b1;
            end else if (pins.start_p || pins.stop_p) begin
                o_bus_collision <= 1'b0;
            end
            if (pins.rise_p && gc_read_reg && state_reg == IBF_TX && tx_live_reg && !sda_drive_low_reg
                && !pins.sda_s && bit_cnt_reg != 4'(ACK_BIT_IDX)) begin
                o_arb_lost <= 1'b1;
            end else if (pins.start_p || pins.stop_p || !enabled) begin
                o_arb_lost <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // pins and status
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_sda_out <= 1'b0;
            o_sda_oe <= 1'b0;
            o_scl_out <= 1'b0;
            o_scl_oe <= 1'b0;
            o_start_seen <= 1'b0;
            o_stop_seen <= 1'b0;
            o_bus_idle <= 1'b0;
        end else begin
            o_sda_out <= 1'b0;
            o_scl_out <= 1'b0;
            o_sda_oe <= enabled && sda_drive_low_reg;
            // slave never originates scl; it only releases it here
            o_scl_oe <= 1'b0;
            o_start_seen <= pins.start_p && enabled;
            o_stop_seen <= pins.stop_p && enabled;
            o_bus_idle <= !pins.busy && pins.scl_s && pins.sda_s;
        end
    end
endmodule

// file: rtl/ibf_pkg.sv
package ibf_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int HOLD_LONG_NS = 300;
    localparam int HOLD_LONG_CYC = (HOLD_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_SHORT_CYC = 1;
    localparam int HOLD_CNT_W = 5;
    // ----------------------------------------
    // framing
    // ----------------------------------------
    localparam int BITS_PER_UNIT = 9;
    localparam int ACK_BIT_IDX = 8;
    localparam logic [4:0] TEN_BIT_HDR = 5'h1E;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] BITCNT_RST = 4'h0;

    typedef enum logic [2:0] {
        IBF_IDLE,
        IBF_ADDR,
        IBF_ADDR_LO,
        IBF_RX,
        IBF_TX,
        IBF_IGNORE
    } ibf_state_t;
endpackage

// file: rtl/ibf_pins_if.sv
`timescale 1ns/1ps
interface ibf_pins_if;
    logic scl_s;
    logic sda_s;
    logic start_p;
    logic stop_p;
    logic rise_p;
    logic fall_p;
    logic busy;
    modport cond (output scl_s, output sda_s, output start_p, output stop_p, output rise_p, output fall_p,
        output busy);
    modport core (input scl_s, input sda_s, input start_p, input stop_p, input rise_p, input fall_p,
        input busy);
endinterface

// file: rtl/ibf_cond_det.sv
`timescale 1ns/1ps
module ibf_cond_det
    import ibf_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_scl,
    input wire logic i_sda,
    ibf_pins_if.cond o_pins
);
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_low_seen_reg;
    logic busy_reg;

    // ----------------------------------------
    // two-stage synchronisers
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], i_scl};
            sda_sync_reg <= {sda_sync_reg[0], i_sda};
            scl_d_reg <= scl_sync_reg[1];
            sda_d_reg <= sda_sync_reg[1];
        end
    end

    assign o_pins.scl_s = scl_sync_reg[1];
    assign o_pins.sda_s = sda_sync_reg[1];
    assign o_pins.rise_p = scl_sync_reg[1] && !scl_d_reg;
    assign o_pins.fall_p = !scl_sync_reg[1] && scl_d_reg;
    // sda moving while scl stays high is a condition, never data
    assign o_pins.start_p = scl_sync_reg[1] && scl_d_reg && sda_d_reg && !sda_sync_reg[1];
    assign o_pins.stop_p = scl_sync_reg[1] && scl_d_reg && !sda_d_reg && sda_sync_reg[1]
        && scl_low_seen_reg;
    assign o_pins.busy = busy_reg;

    // ----------------------------------------
    // scl low qualifier and bus state
    // ----------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scl_low_seen_reg <= 1'b0;
        end else if (o_pins.start_p) begin
            scl_low_seen_reg <= 1'b0;
        end else if (!scl_sync_reg[1]) begin
            scl_low_seen_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_reg <= 1'b0;
        end else if (o_pins.start_p) begin
            busy_reg <= 1'b1;
        end else if (o_pins.stop_p) begin
            busy_reg <= 1'b0;
        end
    end
endmodule

// file: tb/ibf_sva.sv
`timescale 1ns/1ps
module ibf_sva
    import ibf_pkg::*;
#(
    parameter int HOLD_LONG = HOLD_LONG_CYC
)(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_port_enable_bit,
    input wire logic i_i2c_mode,
    input wire logic i_sda_hold_select,
    input wire logic i_start_req,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic o_scl_out,
    input wire logic o_scl_oe,
    input wire logic o_addr_match,
    input wire logic o_prior_match,
    input wire logic o_bus_collision,
    input wire logic o_arb_lost,
    input wire logic o_start_seen,
    input wire logic o_stop_seen
);
    logic scl_q_reg;
    logic low_seen_reg;
    logic [5:0] fall_cnt_reg;
    wire logic en = i_port_enable_bit && i_i2c_mode;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    // counts from the raw scl fall, so the sync delay is part of the measured hold
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            scl_q_reg <= 1'b1;
            fall_cnt_reg <= 6'h00;
        end else begin
            scl_q_reg <= i_scl;
            if (scl_q_reg && !i_scl) begin
                fall_cnt_reg <= 6'h00;
            end else if (fall_cnt_reg != 6'h3F) begin
                fall_cnt_reg <= fall_cnt_reg + 6'h01;
            end
        end
    end
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            low_seen_reg <= 1'b0;
        end else if (o_start_seen) begin
            low_seen_reg <= 1'b0;
        end else if (!i_scl) begin
            low_seen_reg <= 1'b1;
        end
    end
    AST_PINS_ZERO: assert property (!o_scl_oe && !o_scl_out && !o_sda_out)
        else $error("scl driven or sda data not zero");
    AST_START_DET: assert property (en && i_scl && $past(i_scl) && $fell(i_sda) |-> ##[1:4] o_start_seen)
        else $error("start not reported");
    AST_STOP_DET: assert property (en && i_scl && $past(i_scl) && $rose(i_sda) && low_seen_reg
        |-> ##[1:4] o_stop_seen)
        else $error("stop not reported");
    AST_STOP_NEEDS_LOW: assert property (o_stop_seen |-> low_seen_reg)
        else $error("stop without scl low");
    AST_HOLD_LONG: assert property (i_sda_hold_select && $changed(o_sda_oe) |-> fall_cnt_reg >= HOLD_LONG)
        else $error("sda hold too short");
    AST_CHANGE_LOW: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("sda changed while scl high");
    AST_COLL_START: assert property (en && i_start_req && !i_sda && !$past(i_sda) && !$past(i_sda, 2)
        |-> ##[0:3] o_bus_collision)
        else $error("start collision missed");
    AST_ARB_RELEASE: assert property (o_arb_lost |-> !o_sda_oe)
        else $error("driving after lost arbitration");
    AST_PRIOR_CLR: assert property (o_stop_seen |-> ##[0:1] !o_prior_match)
        else $error("prior match kept over stop");
    AST_ACK_AFTER_MATCH: assert property ($rose(o_addr_match) |-> ##[1:40] o_sda_oe)
        else $error("no ack after match");
    COV_START: cover property (o_start_seen);
    COV_PRIOR: cover property ($rose(o_prior_match));
    COV_ARB: cover property ($rose(o_arb_lost));
endmodule

bind ibf_i2c_front ibf_sva #(.HOLD_LONG(HOLD_LONG)) ibf_sva_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_scl(i_scl), .i_sda(i_sda), .i_port_enable_bit(i_port_enable_bit), .i_i2c_mode(i_i2c_mode),
    .i_sda_hold_select(i_sda_hold_select), .i_start_req(i_start_req), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe), .o_addr_match(o_addr_match),
    .o_prior_match(o_prior_match), .o_bus_collision(o_bus_collision), .o_arb_lost(o_arb_lost),
    .o_start_seen(o_start_seen), .o_stop_seen(o_stop_seen));

// file: tb/ibf_master_model.sv
`timescale 1ns/1ps
module ibf_master_model (
    input wire logic i_mclk,
    input wire logic i_sda_wire,
    output logic o_scl_low,
    output logic o_sda_low
);
    // long low phase leaves room for the 300 ns hold plus sync delay
    localparam int LOW_CYC = 24;
    localparam int HIGH_CYC = 4;
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask
    task automatic go_start();
        o_sda_low = 1'b1;
        wt(8);
        o_scl_low = 1'b1;
        wt(2);
    endtask
    task automatic put_bit(input logic b, output logic r);
        wt(10);
        o_sda_low = !b;
        wt(LOW_CYC - 10);
        o_scl_low = 1'b0;
        wt(HIGH_CYC - 1);
        r = i_sda_wire;
        wt(1);
        o_scl_low = 1'b1;
    endtask
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] rd, output logic nine);
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], rd[i]);
        end
        put_bit(last, nine);
        wt(4);
    endtask
    task automatic finish(input logic rs);
        wt(10);
        o_sda_low = !rs;
        wt(LOW_CYC - 10);
        o_scl_low = 1'b0;
        wt(8);
        o_sda_low = rs;
        wt(8);
        if (rs) begin
            o_scl_low = 1'b1;
            wt(2);
        end
    endtask
    task automatic blip();
        o_sda_low = 1'b1;
        wt(8);
        o_sda_low = 1'b0;
        wt(8);
    endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import ibf_pkg::*;
    localparam int LIMIT = 20000;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic en_bit = 1'b1;
    logic mode = 1'b1;
    logic ten = 1'b0;
    logic hold = 1'b0;
    logic gc_en = 1'b0;
    logic start_req = 1'b0;
    logic other_low = 1'b0;
    logic [7:0] addr = 8'h52;
    logic [7:0] addr_lo = 8'h00;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] tx_next = 8'h00;
    logic m_scl_low, m_sda_low, scl_w, sda_w, sda_out, sda_oe, scl_out, scl_oe, rx_valid, tx_load;
    logic ack_in, addr_match, read_req, prior, coll, arb, start_seen, stop_seen, idle;
    logic [7:0] rx_data;
    int n_start = 0;
    int n_stop = 0;
    int n_rx = 0;
    int cyc = 0;
    int checks = 0;
    int err_total = 0;
    // open-drain wires with pull-ups; other_low stands for a second master or slave
    assign sda_w = !(m_sda_low || (sda_oe && !sda_out) || other_low);
    assign scl_w = !(m_scl_low || (scl_oe && !scl_out));
    always #12.5 i_mclk = ~i_mclk;
    ibf_master_model ibf_master_model_inst (.i_mclk(i_mclk), .i_sda_wire(sda_w), .o_scl_low(m_scl_low),
        .o_sda_low(m_sda_low));
    ibf_i2c_front ibf_i2c_front_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_scl(scl_w), .i_sda(sda_w),
        .i_port_enable_bit(en_bit), .i_i2c_mode(mode), .i_ten_bit_mode(ten), .i_sda_hold_select(hold),
        .i_slave_address_reg(addr), .i_slave_address_lo(addr_lo), .i_general_call_en(gc_en),
        .i_tx_data(tx_data), .i_start_req(start_req), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .o_scl_out(scl_out), .o_scl_oe(scl_oe), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
        .o_tx_load(tx_load), .o_ack_in(ack_in), .o_addr_match(addr_match), .o_read_req(read_req),
        .o_prior_match(prior), .o_bus_collision(coll), .o_arb_lost(arb), .o_start_seen(start_seen),
        .o_stop_seen(stop_seen), .o_bus_idle(idle));
    task automatic stop_test();
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            $display("BAD %s exp %h seen %h", nm, exp, seen);
            err_total++;
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_mclk);
        #2;
    endtask
    task automatic send(input logic [7:0] d, input logic exp_nine);
        logic [7:0] rd;
        logic nine;
        ibf_master_model_inst.xfer(d, 1'b1, rd, nine);
        chk("ack", nine, exp_nine);
    endtask
    task automatic rcv(input logic last, input logic [7:0] exp);
        logic [7:0] rd;
        logic nine;
        ibf_master_model_inst.xfer(8'hFF, last, rd, nine);
        chk("rx byte", rd, exp);
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        if (start_seen === 1'b1) n_start++;
        if (stop_seen === 1'b1) n_stop++;
        if (rx_valid === 1'b1) n_rx++;
        if (tx_load === 1'b1) tx_data <= tx_next;
        if (cyc == LIMIT) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        wt(6);
        chk("outs rst", {sda_oe, scl_oe, addr_match, read_req, prior, coll, arb, idle}, 8'h00);
        i_rst_b = 1'b1;
        wt(4);
        chk("idle", idle, 1'b1);
        ibf_master_model_inst.go_start();
        chk("start", {7'(n_start), idle}, 8'h02);
        send(8'h52, 1'b0);
        chk("match w", {addr_match, read_req}, 8'h02);
        send(8'hA5, 1'b0);
        chk("rx", rx_data, 8'hA5);
        chk("rx n", 8'(n_rx), 8'h01);
        ibf_master_model_inst.finish(1'b0);
        wt(4);
        chk("stop", {6'(n_stop), addr_match, idle}, 8'h05);
        ibf_master_model_inst.go_start();
        send(8'h54, 1'b1);
        chk("no match", addr_match, 1'b0);
        ibf_master_model_inst.finish(1'b0);
        tx_data = 8'hC3;
        tx_next = 8'h5A;
        ibf_master_model_inst.go_start();
        send(8'h53, 1'b0);
        chk("read req", read_req, 1'b1);
        rcv(1'b0, 8'hC3);
        chk("ack in", ack_in, 1'b1);
        rcv(1'b1, 8'h5A);
        ibf_master_model_inst.finish(1'b0);
        ibf_master_model_inst.blip();
        chk("blip", 8'(n_start - n_stop), 8'h01);
        other_low = 1'b1;
        wt(8);
        start_req = 1'b1;
        wt(6);
        chk("coll start", coll, 1'b1);
        start_req = 1'b0;
        other_low = 1'b0;
        wt(8);
        en_bit = 1'b0;
        ibf_master_model_inst.go_start();
        en_bit = 1'b1;
        mode = 1'b0;
        send(8'h52, 1'b1);
        ibf_master_model_inst.finish(1'b0);
        chk("off", 8'(n_start), 8'h05);
        mode = 1'b1;
        ten = 1'b1;
        hold = 1'b1;
        addr = 8'h06;
        addr_lo = 8'h9C;
        tx_data = 8'h96;
        ibf_master_model_inst.go_start();
        chk("coll clr", coll, 1'b0);
        send(8'hF6, 1'b0);
        send(8'h9C, 1'b0);
        chk("prior", prior, 1'b1);
        ibf_master_model_inst.finish(1'b1);
        chk("restart", {7'(n_start), prior}, 8'h0F);
        send(8'hF7, 1'b0);
        chk("read 10b", read_req, 1'b1);
        rcv(1'b1, 8'h96);
        ibf_master_model_inst.finish(1'b0);
        wt(4);
        chk("prior clr", prior, 1'b0);
        ten = 1'b0;
        hold = 1'b0;
        gc_en = 1'b1;
        tx_data = 8'hFF;
        ibf_master_model_inst.go_start();
        send(8'h01, 1'b0);
        other_low = 1'b1;
        rcv(1'b1, 8'h00);
        other_low = 1'b0;
        chk("arb", {arb, coll}, 8'h03);
        ibf_master_model_inst.finish(1'b0);
        wt(4);
        chk("arb clr", arb, 1'b0);
        stop_test();
    end
endmodule
